// file: verilog/rtc_periodic_calibration.sv
// Periodic counter correction between the 512 Hz stage and the 100 Hz tick
//
// Contract
// - No correction: exactly 100 ticks out per 512 input pulses.
// - Positive non-zero magnitude: 100 ticks per 511 pulses while active.
// - Negative non-zero magnitude: 100 ticks per 513 pulses while active.
// - Positive N: modified ratio during first N seconds of every eight minutes.
// - Negative N: modified ratio for N seconds of every sixteen minutes.
// - Magnitude is unsigned, bits 4 to 0 of the calibration register.
// - Bit 5 is the sign: one speeds up, zero slows down.
// - Magnitude zero gives no correction for either sign.
// - Each step is about +4.068 ppm or -2.034 ppm on average.
// - With test output enabled, drive the 512 Hz square on the test pin.
// - Test output is taken before correction; calibration never changes it.
// - Correction adds or removes one pulse at the 512 Hz stage only.
`timescale 1ns/100ps
`include "rtc_cal_defines.svh"
module rtc_periodic_calibration (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  pulse_512_i,
    input  wire logic                  square_512_i,
    input  wire logic                  reg_wr_i,
    input  wire rtc_cal_pkg::reg_addr_t reg_addr_i,
    input  wire rtc_cal_pkg::reg_data_t reg_wdata_i,
    output rtc_cal_pkg::reg_data_t      reg_rdata_o,
    output logic                       tick_100_o,
    output logic                       frequency_test_output_o,
    output logic                       correction_active_o
);
    import rtc_cal_pkg::*;

    reg_data_t cal_q;
    reg_data_t cal_d;
    reg_data_t rdata_q;
    reg_data_t rdata_d;
    cal_mag_t  mag_s_q;
    cal_mag_t  mag_s_d;
    logic      sign_s_q;
    logic      sign_s_d;
    span_t     acc_q;
    span_t     acc_d;
    span_t     acc_sum;
    span_t     period;
    logic      tick_q;
    logic      tick_d;
    logic      ft_q;
    logic      ft_d;
    logic      active_q;
    logic      active;
    cal_mode_t mode;
    logic [5:0] sec_cnt;
    logic [3:0] min_cnt;
    logic       sec_wrap;
    logic       min_step;
    logic       tick_wrap;

    // Register port and setting sample
    always_comb begin
        cal_d    = cal_q;
        rdata_d  = 8'h00;
        mag_s_d  = mag_s_q;
        sign_s_d = sign_s_q;
        if (reg_wr_i && reg_addr_i == `CAL_REG_OFFSET) begin
            cal_d = reg_wdata_i;
        end
        if (reg_addr_i == `CAL_REG_OFFSET) begin
            rdata_d = cal_q;
        end
        if (min_step) begin
            mag_s_d  = cal_q[`CAL_MAG_MSB:`CAL_MAG_LSB];
            sign_s_d = cal_q[`CAL_SIGN_BIT];
        end
    end

    // Correction window and divide ratio
    always_comb begin
        active = 1'b0;
        if (mag_s_q != 5'h00 && {2'b00, sec_cnt} < {3'b000, mag_s_q}) begin
            if (sign_s_q) begin
                active = (min_cnt & `POS_CYCLE_MASK) == 4'h0;
            end else begin
                active = min_cnt == 4'h0;
            end
        end
        if (!active) begin
            mode = MODE_NORMAL;
        end else if (sign_s_q) begin
            mode = MODE_FAST;
        end else begin
            mode = MODE_SLOW;
        end
        unique case (mode)
            MODE_NORMAL: period = `PULSES_NORMAL;
            MODE_FAST:   period = `PULSES_FAST;
            MODE_SLOW:   period = `PULSES_SLOW;
            default:     period = `PULSES_NORMAL;
        endcase
    end

    // Rate accumulator: 100 per input pulse, one tick per full period
    always_comb begin
        acc_sum = acc_q + `TICKS_PER_SPAN;
        acc_d   = acc_q;
        tick_d  = 1'b0;
        ft_d    = cal_q[`CAL_FT_BIT] & square_512_i;
        if (pulse_512_i) begin
            if (acc_sum >= period) begin
                acc_d  = acc_sum - period;
                tick_d = 1'b1;
            end else begin
                acc_d = acc_sum;
            end
        end
    end

    assign tick_wrap = tick_d;

    mod_counter #(
        .MODULUS (`TICKS_PER_SECOND),
        .WIDTH   (7)
    ) u_tick_count (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .inc_i   (tick_wrap),
        .count_o (),
        .wrap_o  (sec_wrap)
    );

    mod_counter #(
        .MODULUS (`SECONDS_PER_MINUTE),
        .WIDTH   (6)
    ) u_sec_count (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .inc_i   (sec_wrap),
        .count_o (sec_cnt),
        .wrap_o  ()
    );

    mod_counter #(
        .MODULUS (`MINUTES_PER_CYCLE),
        .WIDTH   (4)
    ) u_min_count (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .inc_i   (sec_wrap && sec_cnt == 6'(`SECONDS_PER_MINUTE - 1)),
        .count_o (min_cnt),
        .wrap_o  ()
    );

    assign min_step = sec_wrap;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_q    <= `CAL_REG_RESET;
            rdata_q  <= 8'h00;
            mag_s_q  <= 5'h00;
            sign_s_q <= 1'b0;
            acc_q    <= 10'h000;
            tick_q   <= 1'b0;
            ft_q     <= 1'b0;
            active_q <= 1'b0;
        end else if (ce_i) begin
            cal_q    <= cal_d;
            rdata_q  <= rdata_d;
            mag_s_q  <= mag_s_d;
            sign_s_q <= sign_s_d;
            acc_q    <= acc_d;
            tick_q   <= tick_d;
            ft_q     <= ft_d;
            active_q <= active;
        end
    end

    assign reg_rdata_o             = rdata_q;
    assign tick_100_o              = tick_q;
    assign frequency_test_output_o = ft_q;
    assign correction_active_o     = active_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence cal_write_s;
        ce_i && reg_wr_i && reg_addr_i == `CAL_REG_OFFSET;
    endsequence

    sequence cal_held_s;
        !(ce_i && reg_wr_i && reg_addr_i == `CAL_REG_OFFSET);
    endsequence

    AST_TICK_FROM_PULSE: assert property (
        $rose(tick_100_o) |-> $past(pulse_512_i))
        else $error("tick without a 512 Hz pulse");
    AST_MAG_ZERO_NORMAL: assert property (
        mag_s_q == 5'h00 |-> period == `PULSES_NORMAL)
        else $error("correction with zero magnitude");
    AST_FAST_PERIOD: assert property (
        active && sign_s_q |-> period == 10'h1FF)
        else $error("fast period not 511");
    AST_SLOW_PERIOD: assert property (
        active && !sign_s_q |-> period == 10'h201)
        else $error("slow period not 513");
    AST_POS_WINDOW: assert property (
        sign_s_q && mag_s_q != 5'h00 && min_cnt[2:0] == 3'h0
            && {2'b00, sec_cnt} < {3'b000, mag_s_q} |-> active)
        else $error("positive window missed");
    AST_NEG_WINDOW: assert property (
        active && !sign_s_q |-> min_cnt == 4'h0)
        else $error("negative correction outside its minute");
    AST_MAG_FIELD: assert property (
        cal_write_s |=> cal_q[4:0] == $past(reg_wdata_i[4:0]))
        else $error("magnitude field not stored");
    AST_SIGN_HELD: assert property (
        cal_write_s ##1 cal_held_s |=> cal_q[5] == $past(reg_wdata_i[5], 2))
        else $error("sign bit not held");
    AST_FT_PATH: assert property (
        $past(ce_i) |-> frequency_test_output_o
            == $past(cal_q[`CAL_FT_BIT] & square_512_i))
        else $error("test output not the raw 512 Hz square");
    AST_ACC_BOUND: assert property (
        acc_q < 10'h201)
        else $error("accumulator out of range");
endmodule

// file: shared/rtc_cal_defines.svh
// Offsets, field positions, reset values and counts of the periodic calibration block
`ifndef RTC_CAL_DEFINES_SVH
`define RTC_CAL_DEFINES_SVH

`define CAL_REG_OFFSET      5'h08
`define CAL_REG_RESET       8'h00
`define CAL_MAG_MSB         4
`define CAL_MAG_LSB         0
`define CAL_SIGN_BIT        5
`define CAL_FT_BIT          6
`define TICKS_PER_SPAN      10'h064
`define PULSES_NORMAL       10'h200
`define PULSES_FAST         10'h1FF
`define PULSES_SLOW         10'h201
`define TICKS_PER_SECOND    100
`define SECONDS_PER_MINUTE  60
`define MINUTES_PER_CYCLE   16
`define POS_CYCLE_MASK      4'h7

`endif

// file: shared/rtc_cal_pkg.sv
// Types of the periodic calibration block
package rtc_cal_pkg;
    typedef logic [4:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [4:0] cal_mag_t;
    typedef logic [9:0] span_t;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_FAST,
        MODE_SLOW
    } cal_mode_t;
endpackage

// file: verilog/mod_counter.sv
// Modulo counter stepped by an increment strobe
`timescale 1ns/100ps
module mod_counter #(
    parameter int MODULUS = 60,
    parameter int WIDTH   = 6
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             inc_i,
    output logic [WIDTH-1:0]      count_o,
    output logic                  wrap_o
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    assign wrap_o  = inc_i && (count_q == WIDTH'(MODULUS - 1));
    assign count_o = count_q;

    always_comb begin
        count_d = count_q;
        if (wrap_o) begin
            count_d = '0;
        end else if (inc_i) begin
            count_d = count_q + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= '0;
        end else if (ce_i) begin
            count_q <= count_d;
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking testbench of the periodic calibration block
`timescale 1ns/100ps
`include "rtc_cal_defines.svh"
module tb;
    import rtc_cal_pkg::*;
    logic      clk_i;
    logic      rst_i;
    logic      ce_i;
    logic      pulse_512_i;
    logic      square_512_i;
    logic      reg_wr_i;
    reg_addr_t reg_addr_i;
    reg_data_t reg_wdata_i;
    reg_data_t reg_rdata_o;
    logic      tick_100_o;
    logic      frequency_test_output_o;
    logic      correction_active_o;
    logic      ft_en;
    int        mismatches;
    int        total_checks;
    int        tick_count;

    rtc_periodic_calibration uut (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .ce_i                    (ce_i),
        .pulse_512_i             (pulse_512_i),
        .square_512_i            (square_512_i),
        .reg_wr_i                (reg_wr_i),
        .reg_addr_i              (reg_addr_i),
        .reg_wdata_i             (reg_wdata_i),
        .reg_rdata_o             (reg_rdata_o),
        .tick_100_o              (tick_100_o),
        .frequency_test_output_o (frequency_test_output_o),
        .correction_active_o     (correction_active_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Counts ticks handed to the fractional-seconds counter
    always @(posedge clk_i) begin
        if (tick_100_o === 1'b1) tick_count <= tick_count + 1;
    end

    task automatic end_of_test;
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %0h seen %0h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic do_reset;
        rst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
    endtask

    task automatic write_reg(reg_addr_t a, reg_data_t d);
        @(negedge clk_i);
        reg_wr_i    = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic read_reg(reg_addr_t a, reg_data_t exp);
        @(negedge clk_i);
        reg_addr_i = a;
        @(negedge clk_i);
        check("reg_rdata_o", 16'(exp), 16'(reg_rdata_o));
    endtask

    // Sends pulses until 100 ticks came out, checking pulse count, window and test pin
    task automatic measure(span_t exp_pulses, logic exp_act);
        int start;
        int pulses;
        start  = tick_count;
        pulses = 0;
        repeat (600) begin
            @(negedge clk_i);
            if (tick_count - start >= 100) break;
            pulse_512_i  = 1'b1;
            square_512_i = ~square_512_i;
            pulses++;
            @(negedge clk_i);
            pulse_512_i = 1'b0;
            check("ft_out", 16'(ft_en & square_512_i),
                  16'(frequency_test_output_o));
            if (pulses == 50) check("active", 16'(exp_act),
                                    16'(correction_active_o));
        end
        check("pulses", 16'(exp_pulses), 16'(pulses));
    endtask

    initial begin
        #150000;
        mismatches++;
        end_of_test;
    end

    initial begin
        rst_i        = 1'b1;
        ce_i         = 1'b1;
        pulse_512_i  = 1'b0;
        square_512_i = 1'b0;
        reg_wr_i     = 1'b0;
        reg_addr_i   = 5'h00;
        reg_wdata_i  = 8'h00;
        ft_en        = 1'b0;
        mismatches   = 0;
        total_checks = 0;
        tick_count   = 0;
        do_reset;
        read_reg(`CAL_REG_OFFSET, `CAL_REG_RESET);
        write_reg(`CAL_REG_OFFSET, 8'h20);
        read_reg(5'h1F, 8'h00);
        read_reg(`CAL_REG_OFFSET, 8'h20);
        repeat (3) measure(`PULSES_NORMAL, 1'b0);
        do_reset;
        write_reg(`CAL_REG_OFFSET, 8'hE2);
        ft_en = 1'b1;
        read_reg(`CAL_REG_OFFSET, 8'hE2);
        measure(`PULSES_NORMAL, 1'b0);
        measure(`PULSES_FAST, 1'b1);
        measure(`PULSES_NORMAL, 1'b0);
        do_reset;
        ft_en = 1'b0;
        @(negedge clk_i);
        ce_i = 1'b0;
        write_reg(`CAL_REG_OFFSET, 8'h05);
        ce_i = 1'b1;
        read_reg(`CAL_REG_OFFSET, 8'h00);
        write_reg(`CAL_REG_OFFSET, 8'h05);
        measure(`PULSES_NORMAL, 1'b0);
        repeat (4) measure(`PULSES_SLOW, 1'b1);
        measure(`PULSES_NORMAL, 1'b0);
        end_of_test;
    end
endmodule
